// File: hw/pilot_scheme_logic.sv
// pilot scheme trip logic with wishbone configuration and status
//
// The implementer's own choices: register access over Wishbone and the address map.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// R1: overreach mode: overreach trip via pickup timer into comparer with received permission.
// R2: overreach and underreach modes: any overreaching trip function keys the transmitter to trip frequency.
// R3: receiver one input is the received trip or blocking signal.
// R4: comparer output passes a pickup timer before producing a trip.
// R5: every trip is gated by the fault detector.
// R6: comparer trips only while out-of-step blocking is inactive.
// R7: overreach mode, two receivers: both must give permission (AND).
// R8: line open by breaker contact keys transmitter continuously.
// R9: two breakers: line open needs both inputs; one breaker uses input a.
// R10: underreach mode: zone 1 trips directly and keys the transmitter.
// R11: underreach mode: overreach plus receiver permission at comparer trips.
// R12: underreach mode, two receivers: receivers combined with OR.
// R13: underreach with two receivers suppresses breaker-open keying.
// R14: blocking mode: overreach inhibits distance blocking functions and stops started carrier.
// R15: blocking mode: trip after coordination timer started by satisfied comparer.
// R16: blocking mode: receiver output removes permission via inverted input.
// R17: blocking mode: local blocking function keys carrier and blocks local comparer.
// R18: ground carrier start: variant one ipb and negseq, two fault detector, three ipb.
// R19: ground directional block held 25 ms extends dropout by 30 ms.
// R20: distance blocking functions get the same extension on their own timer.
// R21: overreach trip outputs override and reset the distance blocking functions.
// R22: transmitter stop input forces the transmitter off.
// R23: pilot disable input turns off all pilot logic.
// R24: timers count a millisecond tick and clear synchronously.
module pilot_scheme_logic #(
  parameter int TICK_CYCLES = pilot_scheme_pkg::TICK_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic breaker_a_open_input_in,
  input wire logic breaker_b_open_input_in,
  input wire logic receiver_one_input_in,
  input wire logic receiver_two_input_in,
  input wire logic transmitter_stop_input_in,
  input wire logic pilot_disable_input_in,
  input wire logic overreach_trip_in,
  input wire logic zone1_trip_in,
  input wire logic distance_block_in,
  input wire logic ground_directional_overcurrent_in,
  input wire logic ground_block_overcurrent_in,
  input wire logic negseq_block_directional_in,
  input wire logic fault_detector_in,
  input wire logic out_of_step_block_in,
  output logic trip_out,
  output logic transmitter_key_out
);

  localparam int TW = pilot_scheme_pkg::TIME_W;
  localparam int NP = pilot_scheme_pkg::PIN_COUNT;
  localparam int NT = pilot_scheme_pkg::PU_COUNT;
  localparam logic [TW-1:0] GROUND_DIRECTIONAL_OVERCURRENT_PU = TW'(pilot_scheme_pkg::TRANSIENT_PICKUP_MS);
  localparam logic [TW-1:0] EXT_DO = TW'(pilot_scheme_pkg::TRANSIENT_DROPOUT_MS);
  localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [NP-1:0] pin_raw;
  logic [NP-1:0] meta_q;
  logic [NP-1:0] pin_q;

  assign pin_raw = {out_of_step_block_in, fault_detector_in, negseq_block_directional_in,
                    ground_block_overcurrent_in, ground_directional_overcurrent_in,
                    distance_block_in, zone1_trip_in, overreach_trip_in,
                    pilot_disable_input_in, transmitter_stop_input_in,
                    receiver_two_input_in, receiver_one_input_in,
                    breaker_b_open_input_in, breaker_a_open_input_in};

  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++) begin : g_sync
      always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          meta_q[gi] <= 1'b0;
          pin_q[gi] <= 1'b0;
        end else begin
          meta_q[gi] <= pin_raw[gi];
          pin_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // wishbone slave
  logic [31:0] ctrl_q;
  logic [31:0] timer_q;
  logic clear_q;
  logic wb_ack_q;
  logic [31:0] wb_dat_q;
  pilot_scheme_pkg::status_type status_q;
  logic req;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // one wait state: ack one edge after the request, dropped the edge after
  assign req = wb_cyc_in && wb_stb_in && !wb_ack_q;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wb_ack_q <= 1'b0;
    end else begin
      wb_ack_q <= req;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl_q <= pilot_scheme_pkg::CTRL_RESET;
      timer_q <= pilot_scheme_pkg::TIMER_RESET;
      clear_q <= 1'b0;
    end else begin
      clear_q <= 1'b0;
      if (req && wb_we_in) begin
        if (wb_adr_in == pilot_scheme_pkg::CTRL_ADDR) begin
          ctrl_q <= merge(ctrl_q, wb_dat_in, wb_sel_in);
          // clear strobe is self-clearing; the bit is kept in ctrl_q but masked on readback
          clear_q <= wb_sel_in[0] && wb_dat_in[pilot_scheme_pkg::CLEAR_BIT];
        end else if (wb_adr_in == pilot_scheme_pkg::TIMER_ADDR) begin
          timer_q <= merge(timer_q, wb_dat_in, wb_sel_in);
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wb_dat_q <= 32'h0000_0000;
    end else if (req && !wb_we_in) begin
      case (wb_adr_in)
        pilot_scheme_pkg::CTRL_ADDR: wb_dat_q <= ctrl_q & ~(32'h1 << pilot_scheme_pkg::CLEAR_BIT);
        pilot_scheme_pkg::TIMER_ADDR: wb_dat_q <= timer_q;
        pilot_scheme_pkg::STATUS_ADDR: wb_dat_q <= 32'(status_q);
        default: wb_dat_q <= 32'h0000_0000;
      endcase
    end
  end

  assign wb_ack_out = wb_ack_q;
  assign wb_dat_out = wb_dat_q;

  //////////////////////////////////////////////////////////////////////////////
  // settings decode
  logic [2:0] scheme;
  logic two_rcvr;
  logic two_brkr;
  logic [1:0] variant;
  logic is_ovr;
  logic is_und;
  logic is_blk;
  logic enabled;

  assign scheme = ctrl_q[pilot_scheme_pkg::SCHEME_LSB +: pilot_scheme_pkg::SCHEME_W];
  assign two_rcvr = ctrl_q[pilot_scheme_pkg::RCVR_BIT];
  assign two_brkr = ctrl_q[pilot_scheme_pkg::BRKR_BIT];
  assign variant = ctrl_q[pilot_scheme_pkg::VARIANT_LSB +: pilot_scheme_pkg::VARIANT_W];
  assign enabled = !pin_q[pilot_scheme_pkg::PIN_DISABLE]; // see R23
  assign is_ovr = enabled && scheme == pilot_scheme_pkg::SCHEME_OVERREACH;
  assign is_und = enabled && scheme == pilot_scheme_pkg::SCHEME_UNDERREACH;
  assign is_blk = enabled && scheme == pilot_scheme_pkg::SCHEME_BLOCKING;

  //////////////////////////////////////////////////////////////////////////////
  // millisecond tick
  logic [31:0] tick_cnt_q;
  logic tick_q;
  // see R24
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tick_cnt_q <= 32'h0000_0000;
      tick_q <= 1'b0;
    end else if (clear_q || tick_cnt_q >= TICK_LAST) begin
      tick_cnt_q <= 32'h0000_0000;
      tick_q <= !clear_q;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
      tick_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // scheme logic
  logic overreach;
  logic line_open;
  logic rx_permit;
  logic [NT-1:0] pu_in;
  logic [NT-1:0] pu_done;
  logic [TW-1:0] pu_set [NT];
  logic ground_directional_overcurrent_ext;
  logic dist_ext;
  logic dist_blk;
  logic gnd_start;
  logic comparer;
  logic trip_d;
  logic key_d;

  assign overreach = pin_q[pilot_scheme_pkg::PIN_OVERREACH];
  // see R9
  assign line_open = two_brkr ?
      (pin_q[pilot_scheme_pkg::PIN_BRK_A] && pin_q[pilot_scheme_pkg::PIN_BRK_B]) :
      pin_q[pilot_scheme_pkg::PIN_BRK_A];

  // receiver one always used; two only with the two-receiver setting
  always_comb begin
    rx_permit = pin_q[pilot_scheme_pkg::PIN_RX_ONE]; // see R3
    if (two_rcvr && is_ovr) begin
      rx_permit = rx_permit && pin_q[pilot_scheme_pkg::PIN_RX_TWO]; // see R7
    end else if (two_rcvr && is_und) begin
      rx_permit = rx_permit || pin_q[pilot_scheme_pkg::PIN_RX_TWO]; // see R12
    end
  end

  // overreaching trips override distance blocking, including its extension
  assign dist_blk = pin_q[pilot_scheme_pkg::PIN_DIST_BLOCK] && !overreach; // see R21

  always_comb begin
    case (variant)
      pilot_scheme_pkg::VARIANT_ONE: gnd_start = pin_q[pilot_scheme_pkg::PIN_IPB] &&
                                                 pin_q[pilot_scheme_pkg::PIN_NEGSEQ]; // see R18
      pilot_scheme_pkg::VARIANT_TWO: gnd_start = pin_q[pilot_scheme_pkg::PIN_FAULT]; // see R18
      pilot_scheme_pkg::VARIANT_THREE: gnd_start = pin_q[pilot_scheme_pkg::PIN_IPB]; // see R18
      default: gnd_start = 1'b0;
    endcase
  end

  assign pu_set[pilot_scheme_pkg::PU_OVR] = timer_q[pilot_scheme_pkg::OVR_LSB +: TW];
  assign pu_set[pilot_scheme_pkg::PU_COORD] = timer_q[pilot_scheme_pkg::COORD_LSB +: TW];
  assign pu_set[pilot_scheme_pkg::PU_GROUND_DIRECTIONAL_OVERCURRENT] = GROUND_DIRECTIONAL_OVERCURRENT_PU;
  assign pu_set[pilot_scheme_pkg::PU_DIST] = GROUND_DIRECTIONAL_OVERCURRENT_PU;

  assign pu_in[pilot_scheme_pkg::PU_OVR] = (is_ovr || is_und) && overreach; // see R1
  assign pu_in[pilot_scheme_pkg::PU_COORD] = comparer; // see R4
  assign pu_in[pilot_scheme_pkg::PU_GROUND_DIRECTIONAL_OVERCURRENT] = is_blk && pin_q[pilot_scheme_pkg::PIN_GROUND_DIRECTIONAL_OVERCURRENT_BLOCK];
  assign pu_in[pilot_scheme_pkg::PU_DIST] = is_blk && dist_blk; // see R20

  // pickup timers: output once the input has stood for the set milliseconds
  generate
    for (gi = 0; gi < NT; gi++) begin : g_pickup
      logic [TW-1:0] cnt_q;
      always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          cnt_q <= '0;
        end else if (clear_q || !pu_in[gi]) begin
          cnt_q <= '0; // see R24
        end else if (tick_q && cnt_q < pu_set[gi]) begin
          cnt_q <= cnt_q + TW'(1);
        end
      end
      assign pu_done[gi] = pu_in[gi] && cnt_q >= pu_set[gi];
    end
  endgenerate

  // dropout extension: armed only after the pickup, so short blocks are not stretched
  logic [TW-1:0] ground_directional_overcurrent_do_q;
  logic [TW-1:0] dist_do_q;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ground_directional_overcurrent_do_q <= '0;
    end else if (clear_q || !is_blk) begin
      ground_directional_overcurrent_do_q <= '0;
    end else if (pu_done[pilot_scheme_pkg::PU_GROUND_DIRECTIONAL_OVERCURRENT]) begin
      ground_directional_overcurrent_do_q <= EXT_DO; // see R19
    end else if (!pu_in[pilot_scheme_pkg::PU_GROUND_DIRECTIONAL_OVERCURRENT] && tick_q && ground_directional_overcurrent_do_q != '0) begin
      ground_directional_overcurrent_do_q <= ground_directional_overcurrent_do_q - TW'(1);
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      dist_do_q <= '0;
    end else if (clear_q || !is_blk || overreach) begin
      dist_do_q <= '0; // see R21
    end else if (pu_done[pilot_scheme_pkg::PU_DIST]) begin
      dist_do_q <= EXT_DO; // see R20
    end else if (!pu_in[pilot_scheme_pkg::PU_DIST] && tick_q && dist_do_q != '0) begin
      dist_do_q <= dist_do_q - TW'(1);
    end
  end

  assign ground_directional_overcurrent_ext = pu_in[pilot_scheme_pkg::PU_GROUND_DIRECTIONAL_OVERCURRENT] || ground_directional_overcurrent_do_q != '0; // see R19
  assign dist_ext = pu_in[pilot_scheme_pkg::PU_DIST] || dist_do_q != '0; // see R20

  // comparer per scheme, always supervised by out-of-step blocking
  always_comb begin
    comparer = 1'b0;
    if (is_ovr || is_und) begin
      comparer = pu_done[pilot_scheme_pkg::PU_OVR] && rx_permit; // see R1 R11
    end else if (is_blk) begin
      comparer = overreach && !pin_q[pilot_scheme_pkg::PIN_RX_ONE] // see R16
                 && !ground_directional_overcurrent_ext && !dist_ext; // see R17
    end
    comparer = comparer && !pin_q[pilot_scheme_pkg::PIN_OSB]; // see R6
  end

  always_comb begin
    trip_d = pu_done[pilot_scheme_pkg::PU_COORD]; // see R4 R15
    if (is_und && pin_q[pilot_scheme_pkg::PIN_ZONE1]) begin
      trip_d = 1'b1; // see R10
    end
    trip_d = trip_d && pin_q[pilot_scheme_pkg::PIN_FAULT]; // see R5
  end

  always_comb begin
    key_d = 1'b0;
    if (is_ovr || is_und) begin
      key_d = overreach; // see R2
      if (is_und && pin_q[pilot_scheme_pkg::PIN_ZONE1]) begin
        key_d = 1'b1; // see R10
      end
      if (line_open && !(is_und && two_rcvr)) begin
        key_d = 1'b1; // see R8 R13
      end
    end else if (is_blk) begin
      // blocking functions key carrier; overreach stops it
      key_d = (ground_directional_overcurrent_ext || dist_ext || gnd_start) && !overreach; // see R17 R14
    end
    key_d = key_d && !pin_q[pilot_scheme_pkg::PIN_TX_STOP]; // see R22
  end

  //////////////////////////////////////////////////////////////////////////////
  // registered outputs and status
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      trip_out <= 1'b0;
      transmitter_key_out <= 1'b0;
    end else begin
      trip_out <= trip_d;
      transmitter_key_out <= key_d;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      status_q <= '0;
    end else begin
      status_q.rx_permit <= rx_permit;
      status_q.dist_extended <= dist_ext;
      status_q.ground_directional_overcurrent_extended <= ground_directional_overcurrent_ext;
      status_q.comparer <= comparer;
      status_q.line_open <= line_open;
      status_q.transmitter_key <= key_d;
      status_q.trip <= trip_d;
    end
  end

endmodule
`default_nettype wire

// File: hw/pilot_scheme_pkg.sv
// constants, register map and types shared by the pilot scheme trip logic
package pilot_scheme_pkg;

  // wishbone register byte offsets
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] TIMER_ADDR = 8'h04;
  localparam logic [7:0] STATUS_ADDR = 8'h08;

  // control register fields
  localparam int SCHEME_LSB = 0;
  localparam int SCHEME_W = 3;
  localparam int RCVR_BIT = 3;
  localparam int BRKR_BIT = 4;
  localparam int VARIANT_LSB = 5;
  localparam int VARIANT_W = 2;
  localparam int CLEAR_BIT = 7;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

  // timer register fields, values in milliseconds
  localparam int TIME_W = 16;
  localparam int OVR_LSB = 0;
  localparam int COORD_LSB = 16;
  localparam logic [31:0] TIMER_RESET = 32'h0008_0004;

  // scheme select encodings
  localparam logic [2:0] SCHEME_OFF = 3'h0;
  localparam logic [2:0] SCHEME_OVERREACH = 3'h1;
  localparam logic [2:0] SCHEME_UNDERREACH = 3'h2;
  localparam logic [2:0] SCHEME_BLOCKING = 3'h4;

  // ground carrier start variants
  localparam logic [1:0] VARIANT_ONE = 2'h1;
  localparam logic [1:0] VARIANT_TWO = 2'h2;
  localparam logic [1:0] VARIANT_THREE = 2'h3;

  // transient blocking timing
  localparam int TRANSIENT_PICKUP_MS = 25;
  localparam int TRANSIENT_DROPOUT_MS = 30;

  // clock and millisecond tick
  localparam int CLK_HZ = 50_000_000;
  localparam int TICK_CYCLES = CLK_HZ / 1000;

  // synchronised pin positions
  localparam int PIN_BRK_A = 0;
  localparam int PIN_BRK_B = 1;
  localparam int PIN_RX_ONE = 2;
  localparam int PIN_RX_TWO = 3;
  localparam int PIN_TX_STOP = 4;
  localparam int PIN_DISABLE = 5;
  localparam int PIN_OVERREACH = 6;
  localparam int PIN_ZONE1 = 7;
  localparam int PIN_DIST_BLOCK = 8;
  localparam int PIN_GROUND_DIRECTIONAL_OVERCURRENT_BLOCK = 9;
  localparam int PIN_IPB = 10;
  localparam int PIN_NEGSEQ = 11;
  localparam int PIN_FAULT = 12;
  localparam int PIN_OSB = 13;
  localparam int PIN_COUNT = 14;

  // pickup timer slots
  localparam int PU_OVR = 0;
  localparam int PU_COORD = 1;
  localparam int PU_GROUND_DIRECTIONAL_OVERCURRENT = 2;
  localparam int PU_DIST = 3;
  localparam int PU_COUNT = 4;

  typedef struct packed {
    logic rx_permit;
    logic dist_extended;
    logic ground_directional_overcurrent_extended;
    logic comparer;
    logic line_open;
    logic transmitter_key;
    logic trip;
  } status_type;

endpackage

// File: verif/pilot_scheme_logic_tb.sv
// self-checking bench for the pilot scheme trip logic
`timescale 1ns/1ps
`default_nettype none
module pilot_scheme_logic_tb;
  localparam logic [13:0] BA = 14'h0001, BB = 14'h0002, R1 = 14'h0004, R2 = 14'h0008;
  localparam logic [13:0] ST = 14'h0010, DI = 14'h0020, OV = 14'h0040, Z1 = 14'h0080;
  localparam logic [13:0] DB = 14'h0100, GD = 14'h0200, IP = 14'h0400, NS = 14'h0800;
  localparam logic [13:0] FD = 14'h1000, OS = 14'h2000;
  logic clk_in, rst_b_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out, probe;
  logic trip_out, transmitter_key_out, rx_one, rx_two;
  logic [7:0] wb_adr_in;
  logic [3:0] wb_sel_in, e;
  logic [31:0] wb_dat_in, wb_dat_out;
  logic [13:0] pin_v, r;
  logic [31:0] rd_q[$];
  logic [3:0] pin_q[$];
  int bad_count = 0;
  int num_checks = 0;
  ////////////////////////////////////////////////////////////////////////////
  pilot_scheme_logic #(.TICK_CYCLES(10)) u_dut (.clk_in, .rst_b_in, .wb_cyc_in, .wb_stb_in,
    .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out,
    .breaker_a_open_input_in(pin_v[0]), .breaker_b_open_input_in(pin_v[1]),
    .receiver_one_input_in(rx_one), .receiver_two_input_in(rx_two),
    .transmitter_stop_input_in(pin_v[4]), .pilot_disable_input_in(pin_v[5]),
    .overreach_trip_in(pin_v[6]), .zone1_trip_in(pin_v[7]), .distance_block_in(pin_v[8]),
    .ground_directional_overcurrent_in(pin_v[9]), .ground_block_overcurrent_in(pin_v[10]),
    .negseq_block_directional_in(pin_v[11]), .fault_detector_in(pin_v[12]),
    .out_of_step_block_in(pin_v[13]), .trip_out, .transmitter_key_out);
  remote_terminal_model #(.LAG(3)) u_far (.clk_in, .key_one_in(pin_v[2]),
    .key_two_in(pin_v[3]), .rx_one_out(rx_one), .rx_two_out(rx_two));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    int n;
    @(posedge clk_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= w;
    wb_adr_in <= a;
    wb_sel_in <= s;
    wb_dat_in <= d;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (wb_ack_out !== 1'b1 && n < 20);
    if (wb_ack_out !== 1'b1) begin
      bad_count++;
      complete_run();
    end
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    rd_q.push_back(x);
    wb(1'b0, a, 4'hf, 32'h0);
  endtask
  task automatic cfg(input logic [31:0] v);
    wb(1'b1, 8'h00, 4'h1, v);
  endtask
  // outputs are levels, so each note is taken by a one-cycle probe strobe
  task automatic step(input logic [13:0] v, input int n, input logic [1:0] x,
                      input logic [1:0] m);
    @(posedge clk_in);
    pin_v <= v;
    repeat (n) @(posedge clk_in);
    pin_q.push_back({m, x});
    probe <= 1'b1;
    @(posedge clk_in);
    probe <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_in) begin
    if (wb_ack_out === 1'b1 && wb_we_in === 1'b0 && rd_q.size() > 0) begin
      check(wb_dat_out, rd_q.pop_front());
    end
    if (probe === 1'b1) begin
      e = pin_q.pop_front();
      check({30'h0, {trip_out, transmitter_key_out} & e[3:2]}, {30'h0, e[1:0] & e[3:2]});
    end
  end
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  initial begin
    logic [31:0] vt[3] = '{32'h24, 32'h44, 32'h64};
    logic [13:0] pos[3] = '{IP | NS, FD, IP};
    logic [13:0] neg[3] = '{IP, IP | NS, NS};
    rst_b_in = 1'b0;
    {wb_cyc_in, wb_stb_in, wb_we_in, probe} = 4'h0;
    {wb_adr_in, wb_sel_in, wb_dat_in} = 44'h0;
    pin_v = 14'h0;
    void'($urandom(16250));
    repeat (16) @(posedge clk_in);
    rst_b_in <= 1'b1;
    rd(8'h00, 32'h0000_0001);
    rd(8'h04, 32'h0008_0004);
    wb(1'b1, 8'h08, 4'hf, 32'hffff_ffff);
    rd(8'h08, 32'h0);
    wb(1'b1, 8'h0c, 4'hf, 32'hffff_ffff);
    rd(8'h0c, 32'h0);
    wb(1'b1, 8'h04, 4'h1, 32'hffff_ff01);
    rd(8'h04, 32'h0008_0001);
    wb(1'b1, 8'h04, 4'hf, 32'h0002_0001);
    cfg(32'h81);
    rd(8'h00, 32'h0000_0001);
    step(OV | FD, 30, 2'b01, 2'b11);
    step(OV | FD | R1, 8, 2'b01, 2'b11);
    step(OV | FD | R1, 70, 2'b11, 2'b11);
    rd(8'h08, 32'h0000_004b);
    step(OV | FD | R1 | OS, 8, 2'b01, 2'b11);
    step(OV | R1, 8, 2'b01, 2'b11);
    step(BA, 8, 2'b01, 2'b11);
    step(BB, 8, 2'b00, 2'b11);
    cfg(32'h09);
    step(OV | FD | R1, 70, 2'b01, 2'b11);
    step(OV | FD | R1 | R2, 70, 2'b11, 2'b11);
    cfg(32'h11);
    step(BA, 8, 2'b00, 2'b11);
    step(BA | BB, 8, 2'b01, 2'b11);
    cfg(32'h02);
    step(Z1 | FD, 6, 2'b11, 2'b11);
    step(OV | FD | R1, 70, 2'b10, 2'b10);
    step(BA, 8, 2'b01, 2'b11);
    cfg(32'h0a);
    step(OV | FD | R2, 70, 2'b10, 2'b10);
    step(BA, 8, 2'b00, 2'b11);
    cfg(32'h04);
    step(OV | FD, 8, 2'b00, 2'b11);
    step(OV | FD, 70, 2'b10, 2'b11);
    step(OV | FD | R1, 8, 2'b00, 2'b11);
    step(DB, 8, 2'b01, 2'b11);
    step(DB | OV | FD, 70, 2'b10, 2'b11);
    step(DB | ST, 8, 2'b00, 2'b11);
    step(GD | OV | FD, 70, 2'b00, 2'b11);
    for (int i = 0; i < 3; i++) begin
      cfg(vt[i]);
      step(pos[i], 8, 2'b01, 2'b01);
      step(neg[i], 8, 2'b00, 2'b01);
    end
    cfg(32'h04);
    step(GD, 300, 2'b01, 2'b11);
    step(OV | FD, 200, 2'b00, 2'b11);
    step(OV | FD, 200, 2'b10, 2'b11);
    step(GD, 100, 2'b01, 2'b11);
    step(OV | FD, 70, 2'b10, 2'b11);
    step(GD, 200, 2'b01, 2'b11);
    cfg(32'h84);
    step(GD, 100, 2'b01, 2'b11);
    step(OV | FD, 70, 2'b10, 2'b11);
    step(DB, 300, 2'b01, 2'b11);
    step(14'h0, 200, 2'b01, 2'b11);
    step(14'h0, 200, 2'b00, 2'b11);
    for (int i = 0; i < 16; i++) begin
      r = 14'($urandom());
      if (i % 2 == 0) begin
        step(r | DI, 5, 2'b00, 2'b11);
      end else begin
        step((r | ST) & ~FD, 5, 2'b00, 2'b11);
      end
    end
    complete_run();
  end
endmodule
`default_nettype wire

// File: verif/pilot_scheme_props.sv
// port-level assertion checker for the pilot scheme trip logic
`timescale 1ns/1ps
`default_nettype none
module pilot_scheme_props (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  input wire logic transmitter_stop_input_in,
  input wire logic pilot_disable_input_in,
  input wire logic overreach_trip_in,
  input wire logic zone1_trip_in,
  input wire logic fault_detector_in,
  input wire logic out_of_step_block_in,
  input wire logic trip_out,
  input wire logic transmitter_key_out
);
  logic [2:0] scheme_q;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  ////////////////////////////////////////////////////////////////////////////
  // scheme mirror, updated at the edge where the block takes the write
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      scheme_q <= 3'h1;
    end else if (wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out && wb_sel_in[0]
                 && wb_adr_in == 8'h00) begin
      scheme_q <= wb_dat_in[2:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence s_take;
    wb_cyc_in && wb_stb_in && !wb_ack_out;
  endsequence
  sequence s_hole_read;
    s_take ##0 (!wb_we_in && wb_adr_in == 8'h0c);
  endsequence
  property p_ack_next;
    s_take |=> wb_ack_out ##1 !wb_ack_out;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack not a single cycle after request");
  property p_ack_cause;
    $rose(wb_ack_out) |-> $past(wb_stb_in) && $past(wb_cyc_in);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_hole_zero;
    s_hole_read |=> wb_dat_out == 32'h0;
  endproperty
  a_hole_zero: assert property (p_hole_zero) else $error("unmapped read not zero");
  // pins need three edges to reach the outputs, so causes are held at least four samples
  property p_fault_gate;
    (!fault_detector_in) [*4] |-> !trip_out;
  endproperty
  a_fault_gate: assert property (p_fault_gate) else $error("trip without fault");
  property p_osb;
    (out_of_step_block_in && !zone1_trip_in) [*6] |-> !trip_out;
  endproperty
  a_osb: assert property (p_osb) else $error("trip during out of step block");
  property p_stop;
    transmitter_stop_input_in [*4] |-> !transmitter_key_out;
  endproperty
  a_stop: assert property (p_stop) else $error("key while stop held");
  property p_disable;
    pilot_disable_input_in [*4] |-> !transmitter_key_out && !trip_out;
  endproperty
  a_disable: assert property (p_disable) else $error("output while disabled");
  property p_ovr_key;
    (scheme_q == 3'h1 && overreach_trip_in && !transmitter_stop_input_in
     && !pilot_disable_input_in) [*4] |-> transmitter_key_out;
  endproperty
  a_ovr_key: assert property (p_ovr_key) else $error("overreach did not key");
  property p_blk_stop;
    (scheme_q == 3'h4 && overreach_trip_in) [*4] |-> !transmitter_key_out;
  endproperty
  a_blk_stop: assert property (p_blk_stop) else $error("carrier not stopped");
  property p_zone1;
    (scheme_q == 3'h2 && zone1_trip_in && fault_detector_in && !pilot_disable_input_in
     && !out_of_step_block_in && !transmitter_stop_input_in) [*4]
     |-> trip_out && transmitter_key_out;
  endproperty
  a_zone1: assert property (p_zone1) else $error("zone 1 direct trip missing");
endmodule

bind pilot_scheme_logic pilot_scheme_props u_props (.clk_in, .rst_b_in, .wb_cyc_in,
  .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out,
  .transmitter_stop_input_in, .pilot_disable_input_in, .overreach_trip_in, .zone1_trip_in,
  .fault_detector_in, .out_of_step_block_in, .trip_out, .transmitter_key_out);
`default_nettype wire

// File: verif/remote_terminal_model.sv
// remote terminals and channel equipment feeding the two receiver pins
`timescale 1ns/1ps
`default_nettype none
module remote_terminal_model #(
  parameter int LAG = 3
) (
  input wire logic clk_in,
  input wire logic key_one_in,
  input wire logic key_two_in,
  output logic rx_one_out,
  output logic rx_two_out
);
  logic [LAG-1:0] one_q;
  logic [LAG-1:0] two_q;
  // channel delay; a longer lag stands for a slow tone set, never a faster one
  always_ff @(posedge clk_in) begin
    one_q <= {one_q[LAG-2:0], key_one_in};
    two_q <= {two_q[LAG-2:0], key_two_in};
  end
  assign rx_one_out = one_q[LAG-1];
  assign rx_two_out = two_q[LAG-1];
endmodule
`default_nettype wire
